// ### logic/dtsr_cfg.svh
// address map, field positions and reset values of the trigger/status bank
// ****************************************************************
// Overview of operation
// R1 - writing one to comparator_flag_clear clears that channel's comparator latches, self-clears
// R2 - writing one to margin_low_trigger launches margin-low once; zero does nothing
// R3 - writing one to margin_high_trigger launches margin-high once; zero does nothing
// R4 - waveform_run bit is read/write; generation runs while one, stops at zero
// R5 - trigger register also answers at PMBus page FFh, command E5h
// R6 - status register also answers at PMBus command E6h on common page
// R7 - status bit 15 shows factory load CRC failure; software reset clears it
// R8 - status bit 14 shows user memory load CRC failure
// R9 - user CRC failure never blocks host commands or any operation
// R10 - software reset clears user CRC failure; host reprograms memory to restore
// R11 - status bits 12..9 show channel 3..0 busy; host waits for zero
// R12 - write-only trigger bits and reserved status bits 13, 8 read zero
// ****************************************************************
`ifndef DTSR_CFG_SVH
`define DTSR_CFG_SVH

`define DTSR_ADDR_TRIG       8'h21
`define DTSR_ADDR_STATUS     8'h22
`define DTSR_PMB_PAGE_COMMON 8'hFF
`define DTSR_PMB_CMD_TRIG    8'hE5
`define DTSR_PMB_CMD_STATUS  8'hE6
`define DTSR_TRIG_RESET      16'h0000
`define DTSR_NCH             4
`define DTSR_NIB_CLR         3
`define DTSR_NIB_LO          2
`define DTSR_NIB_HI          1
`define DTSR_NIB_RUN         0
`define DTSR_ST_FACTORY      15
`define DTSR_ST_USER         14
`define DTSR_ST_BUSY_LO      9
`define DTSR_ST_ID_LO        2

`endif

// ### logic/dtsr_pkg.sv
// shared types of the trigger/status bank
package dtsr_pkg;
  typedef logic [15:0] dtsr_word_t;
  typedef logic [3:0]  dtsr_nib_t;
endpackage

// ### logic/dtsr_chan.sv
// one channel slice of the trigger register
`timescale 1ns/10ps
`default_nettype none
`include "dtsr_cfg.svh"
module dtsr_chan
  import dtsr_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  // accepted write of this channel's nibble
  input  wire logic  i_wr,
  input  wire dtsr_nib_t i_nib,
  // channel commands
  output logic       o_comparator_flag_clear,
  output logic       o_margin_low_trigger,
  output logic       o_margin_high_trigger,
  output logic       o_waveform_run
);
  // clear and margin command bits are one-cycle pulses, so nothing is stored to read back; waveform_run is held
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_comparator_flag_clear <= 1'b0;
      o_margin_low_trigger    <= 1'b0;
      o_margin_high_trigger   <= 1'b0;
      o_waveform_run          <= 1'b0;
    end else begin
      o_comparator_flag_clear <= i_wr & i_nib[`DTSR_NIB_CLR]; // R1
      o_margin_low_trigger    <= i_wr & i_nib[`DTSR_NIB_LO];  // R2
      o_margin_high_trigger   <= i_wr & i_nib[`DTSR_NIB_HI];  // R3
      if (i_wr) begin
        o_waveform_run <= i_nib[`DTSR_NIB_RUN]; // R4
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/dtsr_top.sv
// trigger and general status registers of the quad converter
`timescale 1ns/10ps
`default_nettype none
`include "dtsr_cfg.svh"
module dtsr_top
  import dtsr_pkg::*;
#(
  // value is arbitrary
  parameter logic [5:0] PART_IDENTIFIER     = 6'h2A,
  parameter logic [1:0] REVISION_IDENTIFIER = 2'h0
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // register port from the serial front end
  input  wire logic        i_pmbus,
  input  wire logic [7:0]  i_page,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_wr,
  input  wire dtsr_word_t  i_wdata,
  input  wire logic        i_rd,
  output dtsr_word_t       o_rdata,
  output logic             o_rvalid,
  // device events
  input  wire logic        i_soft_reset,
  input  wire logic        i_factory_crc_fail,
  input  wire logic        i_user_crc_fail,
  input  wire dtsr_nib_t   i_chan_busy,
  // channel commands
  output dtsr_nib_t        o_comparator_flag_clear,
  output dtsr_nib_t        o_margin_low_trigger,
  output dtsr_nib_t        o_margin_high_trigger,
  output dtsr_nib_t        o_waveform_run
);
  // ****************************************************************
  // status state and read sources
  // ****************************************************************
  logic       factory_err_reg;
  logic       user_err_reg;
  dtsr_nib_t  busy_reg;
  wire dtsr_word_t trig_rd;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire logic hit_trig_pmb = i_pmbus && i_page == `DTSR_PMB_PAGE_COMMON
                            && i_addr == `DTSR_PMB_CMD_TRIG; // R5
  wire logic hit_stat_pmb = i_pmbus && i_page == `DTSR_PMB_PAGE_COMMON
                            && i_addr == `DTSR_PMB_CMD_STATUS; // R6
  wire logic sel_trig = hit_trig_pmb
                        || (!i_pmbus && i_addr == `DTSR_ADDR_TRIG);
  wire logic sel_stat = hit_stat_pmb
                        || (!i_pmbus && i_addr == `DTSR_ADDR_STATUS);
  // the crc flags deliberately play no part here: writes land except in a busy channel
  wire logic wr_trig  = i_wr & sel_trig; // R9

  // ****************************************************************
  // channel slices
  // ****************************************************************
  // nibble of channel n sits at bits 15-4n..12-4n
  genvar n;
  generate
    for (n = 0; n < `DTSR_NCH; n = n + 1) begin : g_ch
      // a busy channel refuses its nibble; host waits for busy low
      wire logic ch_wr = wr_trig & ~busy_reg[n]; // R11
      dtsr_chan u_chan (
        .i_clk                   (i_clk),
        .i_resetn                (i_resetn),
        .i_wr                    (ch_wr),
        .i_nib                   (i_wdata[15-4*n -: 4]),
        .o_comparator_flag_clear (o_comparator_flag_clear[n]),
        .o_margin_low_trigger    (o_margin_low_trigger[n]),
        .o_margin_high_trigger   (o_margin_high_trigger[n]),
        .o_waveform_run          (o_waveform_run[n])
      );
      assign trig_rd[15-4*n -: 4] = {3'b000, o_waveform_run[n]}; // R12
    end
  endgenerate

  // ****************************************************************
  // status flags
  // ****************************************************************
  // set wins over a software reset in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      factory_err_reg <= 1'b0;
      user_err_reg    <= 1'b0;
      busy_reg        <= 4'h0;
    end else begin
      factory_err_reg <= i_factory_crc_fail
                         | (factory_err_reg & ~i_soft_reset); // R7
      user_err_reg    <= i_user_crc_fail
                         | (user_err_reg & ~i_soft_reset); // R8 R10
      busy_reg        <= i_chan_busy; // R11
    end
  end

  // bits 13 and 8 stay zero
  wire dtsr_word_t stat_rd = {factory_err_reg, user_err_reg, 1'b0,
                              busy_reg[3], busy_reg[2], busy_reg[1],
                              busy_reg[0], 1'b0, PART_IDENTIFIER,
                              REVISION_IDENTIFIER}; // R7 R8 R11 R12
  wire dtsr_word_t rd_mux = sel_trig ? trig_rd :
                            sel_stat ? stat_rd : 16'h0000;

  // ****************************************************************
  // read return
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/dtsr_far_model.sv
// channel datapaths and memory loader feeding the status sources
`timescale 1ns/10ps
`default_nettype none
module dtsr_far_model
  import dtsr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire dtsr_nib_t  i_busy_req,
  input  wire logic [1:0] i_bad_load,
  output dtsr_nib_t       o_busy,
  output logic [1:0]      o_fail
);
  // busy comes from clocked channel logic, so it moves only after an edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {o_busy, o_fail} <= '0;
    end else begin
      o_busy <= i_busy_req;
      o_fail <= i_bad_load;
    end
  end
endmodule
`default_nettype wire

// ### verification/dtsr_top_assertions.sv
// port checks of the trigger/status bank
`timescale 1ns/10ps
`default_nettype none
module dtsr_top_assertions
  import dtsr_pkg::*;
(
  input wire logic       i_clk, i_resetn, i_pmbus, i_wr, i_rd, o_rvalid,
  input wire logic [7:0] i_page, i_addr,
  input wire dtsr_word_t i_wdata, o_rdata,
  input wire dtsr_nib_t  i_chan_busy, o_waveform_run, o_comparator_flag_clear,
  input wire dtsr_nib_t  o_margin_low_trigger, o_margin_high_trigger
);
  dtsr_nib_t busy_reg;
  wire logic tw = i_wr && (i_pmbus ? i_page == 8'hFF && i_addr == 8'hE5
                                   : i_addr == 8'h21);
  wire logic tr = i_rd && (i_pmbus ? i_page == 8'hFF && i_addr == 8'hE5
                                   : i_addr == 8'h21);
  wire logic sr = i_rd && (i_pmbus ? i_page == 8'hFF && i_addr == 8'hE6
                                   : i_addr == 8'h22);
  wire dtsr_nib_t ok = ~busy_reg;
  wire dtsr_word_t d = i_wdata;
  wire dtsr_nib_t cv = {d[3], d[7], d[11], d[15]} & ok;
  wire dtsr_nib_t lv = {d[2], d[6], d[10], d[14]} & ok;
  wire dtsr_nib_t hv = {d[1], d[5], d[9], d[13]} & ok;
  wire dtsr_nib_t rv = {d[0], d[4], d[8], d[12]};
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) busy_reg <= '0;
    else busy_reg <= i_chan_busy;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  clear_pulse_a: assert property (tw |=> o_comparator_flag_clear == $past(cv))
    else $error("clear pulse wrong");
  low_pulse_a: assert property (tw |=> o_margin_low_trigger == $past(lv))
    else $error("margin low pulse wrong");
  high_pulse_a: assert property (tw |=> o_margin_high_trigger == $past(hv))
    else $error("margin high pulse wrong");
  pulses_idle_a: assert property (!tw |=> (o_comparator_flag_clear
    | o_margin_low_trigger | o_margin_high_trigger) == 4'h0)
    else $error("trigger pulse without write");
  run_hold_a: assert property (!tw |=> $stable(o_waveform_run))
    else $error("run changed without write");
  run_set_a: assert property (tw |=>
    ((o_waveform_run ^ $past(rv)) & $past(ok)) == 4'h0)
    else $error("run not taken");
  busy_keep_a: assert property (tw |=>
    ((o_waveform_run ^ $past(o_waveform_run)) & $past(busy_reg)) == 4'h0)
    else $error("busy channel took command");
  status_read_a: assert property (sr |=> o_rvalid && !o_rdata[13]
    && !o_rdata[8] && o_rdata[12:9] == $past(busy_reg))
    else $error("status read wrong");
  trig_read_a: assert property (tr |=> o_rvalid && (o_rdata & 16'hEEEE) == 0
    && {o_rdata[0], o_rdata[4], o_rdata[8], o_rdata[12]} == $past(o_waveform_run))
    else $error("trigger read wrong");
endmodule
bind dtsr_top dtsr_top_assertions dtsr_top_assertions_i (.*);
`default_nettype wire

// ### verification/test_dtsr_trigger_status_regs.sv
// self-checking bench of the trigger/status bank
`timescale 1ns/10ps
`default_nettype none
module test_dac_trigger_status_regs import dtsr_pkg::*;;
  logic i_clk = 0, i_resetn, i_pmbus = 0, i_wr = 0, i_rd = 0, o_rvalid;
  logic i_soft_reset = 0, i_factory_crc_fail, i_user_crc_fail;
  logic [7:0] i_page = 8'h00, i_addr = 8'h00;
  logic [1:0] bad = 2'h0;
  dtsr_word_t i_wdata = 16'h0000, o_rdata, exp_q[$];
  dtsr_nib_t i_chan_busy, busy_req = 4'h0, run_exp = 4'h1, o_waveform_run;
  dtsr_nib_t o_comparator_flag_clear, o_margin_low_trigger, o_margin_high_trigger;
  logic [31:0] seed = 32'h7B2D14D5;
  int miscompares = 0, samples_checked = 0;
  always #4 i_clk = ~i_clk;
  dtsr_top dtsr_top_i (.*);
  dtsr_far_model dtsr_far_model_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_busy_req(busy_req), .i_bad_load(bad), .o_busy(i_chan_busy),
    .o_fail({i_factory_crc_fail, i_user_crc_fail}));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h0);
  endfunction
  function automatic dtsr_word_t trig(input dtsr_nib_t r);
    return {3'h0, r[0], 3'h0, r[1], 3'h0, r[2], 3'h0, r[3]};
  endfunction
  // one bus cycle per call, so back-to-back calls give back-to-back requests
  task automatic op(input logic [15:0] pa, input logic w, r,
                    input dtsr_word_t dat, e);
    @(posedge i_clk);
    {i_page, i_addr} <= pa;
    i_pmbus <= pa[15:8] != 8'h00;
    {i_wr, i_rd, i_wdata} <= {w, r, dat};
    if (r) exp_q.push_back(e);
  endtask
  task automatic chk_rd(input dtsr_word_t e);
    samples_checked++;
    if (o_rdata !== e) begin
      miscompares++;
      $display("MISMATCH %0t read %h expected %h", $time, o_rdata, e);
    end
  endtask
  always @(negedge i_clk) if (o_rvalid === 1'b1) chk_rd(exp_q.pop_front());
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_clk);
    miscompares++;
    test_done;
  end
  initial begin
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    op(16'h0021, 0, 1, 0, 16'h0000);
    op(16'h0022, 0, 1, 0, 16'h00A8);
    op(16'h0021, 1, 0, 16'hFFFF, 0);
    op(16'h0021, 0, 1, 0, 16'h1111);
    op(16'hFFE5, 1, 0, 16'h7000, 0);
    op(16'hFFE6, 0, 1, 0, 16'h00A8);
    op(16'hFFE5, 0, 1, 0, trig(run_exp));
    op(16'h01E6, 0, 1, 0, 16'h0000);
    op(16'h0023, 0, 1, 0, 16'h0000);
    $display("test access done");
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      busy_req <= seed[3:0];
      repeat (3) op(0, 0, 0, 0, 0);
      op(16'h0021, 1, 0, seed[31:16], 0);
      run_exp = (run_exp & seed[3:0])
        | ({seed[16], seed[20], seed[24], seed[28]} & ~seed[3:0]);
      op(16'h0021, 0, 1, 0, trig(run_exp));
      op(16'h0022, 0, 1, 0, {3'h0, seed[3:0], 9'h0A8});
    end
    $display("test busy done");
    busy_req <= 4'h0;
    bad <= 2'h3;
    op(0, 0, 0, 0, 0);
    bad <= 2'h0;
    repeat (3) op(0, 0, 0, 0, 0);
    op(16'h0022, 0, 1, 0, 16'hC0A8);
    op(16'h0021, 1, 0, 16'hFFFF, 0);
    op(16'h0021, 0, 1, 0, 16'h1111);
    i_soft_reset <= 1'b1;
    op(0, 0, 0, 0, 0);
    i_soft_reset <= 1'b0;
    op(0, 0, 0, 0, 0);
    op(16'h0022, 0, 1, 0, 16'h00A8);
    repeat (3) op(0, 0, 0, 0, 0);
    $display("test crc done");
    test_done;
  end
endmodule
`default_nettype wire
